// >>> adc_filter_reset_timing.sv
// Functional notes
// [R01] Register writes, resync and start rise reset the filter automatically.
// [R02] Reset command and low reset pin also reset the filter.
// [R03] Resync reset takes effect two system clocks after its last bit.
// [R04] Resync reset pulse lasts two multiplier clock cycles.
// [R05] Input select write resets filter even if value unchanged.
// [R06] Input select write pulse lasts two system clock periods.
// [R07] Bias, reference or gain/rate write resets filter regardless of value.
// [R08] That reset holds 32 modulator clocks after the write.
// [R09] Overlapping active-low pulses combine by AND.
// [R10] First conversion after resync or input select uses short table.
// [R11] First conversion after other resets uses long table.
// [R12] Later conversions use the steady-state table.
// [R13] Each completed conversion drives conversion done low.
// [R14] Each configuration byte acts once fully received.
// [R15] A new reset abandons the conversion and restarts first-conversion count.
`timescale 1ns/1ps
`default_nettype none
module adc_filter_reset_timing
    import filt_pkg::*;
#(
    parameter int MOD_DIV_P = filt_pkg::MOD_DIV,
    parameter int MULT_DIV_P = filt_pkg::MULT_DIV
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic i_reset_pin_n,
    input wire logic i_start_pin,
    input wire logic i_byte_done,
    input wire logic i_wr_input_select,
    input wire logic i_wr_bias_voltage,
    input wire logic i_wr_reference_select,
    input wire logic i_wr_gain_rate,
    input wire logic [filt_pkg::RATE_W-1:0] i_gain_rate_rate,
    input wire logic i_resync_cmd,
    input wire logic i_reset_cmd,
    input wire logic i_wake_command,
    output logic o_filter_reset_n,
    output logic o_conversion_done_flag_n,
    output logic o_conv_pulse
);
    import filt_pkg::*;

    function automatic logic [CNT_W-1:0] first_short(input logic [RATE_W-1:0] r);
        case (r)
            4'h0: first_short = 20'hc7420;
            4'h1: first_short = 20'h63a20;
            4'h2: first_short = 20'h31d20;
            4'h3: first_short = 20'h18eb8;
            4'h4: first_short = 20'h0c778;
            4'h5: first_short = 20'h063d8;
            4'h6: first_short = 20'h031fc;
            4'h7: first_short = 20'h0191c;
            4'h8: first_short = 20'h0103c;
            default: first_short = 20'h0083c;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] first_long(input logic [RATE_W-1:0] r);
        case (r)
            4'h0: first_long = 20'hc8429;
            4'h1: first_long = 20'h64a29;
            4'h2: first_long = 20'h32d29;
            4'h3: first_long = 20'h192c2;
            4'h4: first_long = 20'h0cb82;
            4'h5: first_long = 20'h067e2;
            4'h6: first_long = 20'h03402;
            4'h7: first_long = 20'h01b22;
            4'h8: first_long = 20'h01242;
            default: first_long = 20'h00942;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] steady(input logic [RATE_W-1:0] r);
        case (r)
            4'h0: steady = 20'hc7400;
            4'h1: steady = 20'h63a00;
            4'h2: steady = 20'h31d00;
            4'h3: steady = 20'h18e80;
            4'h4: steady = 20'h0c740;
            4'h5: steady = 20'h063a0;
            4'h6: steady = 20'h031c0;
            4'h7: steady = 20'h018e0;
            4'h8: steady = 20'h01000;
            default: steady = 20'h00800;
        endcase
    endfunction

    typedef struct packed {
        logic rst_pin_s1;
        logic rst_pin_s2;
        logic start_s1;
        logic start_s2;
        logic start_prev;
        logic [1:0] sync_dly;
        logic [7:0] mod_div;
        logic [7:0] mult_div;
        logic [RATE_W-1:0] rate;
        logic short_first;
        logic pend_short;
        logic [CNT_W-1:0] cnt;
        conv_state_t st;
        logic done_n;
        logic conv_pulse;
    } st_t;
    st_t s_q, s_d;

    logic mod_tick, mult_tick, start_rise, pin_rst;
    logic trig_sync, trig_input_sel, trig_cfg;
    logic pulse_sync_n, pulse_sel_n, pulse_cfg_n, any_trig;
    logic trig_long;

    assign mod_tick = (s_q.mod_div == 8'(MOD_DIV_P - 1));
    assign mult_tick = (s_q.mult_div == 8'(MULT_DIV_P - 1));
    assign start_rise = s_q.start_s2 && !s_q.start_prev;
    assign pin_rst = !s_q.rst_pin_s2;
    // [R03] Resync delayed two clocks
    assign trig_sync = s_q.sync_dly[1];
    // [R05] Any input select write
    assign trig_input_sel = i_byte_done && i_wr_input_select;
    // [R14] Act at byte completion
    assign trig_cfg = i_byte_done &&
        (i_wr_bias_voltage || i_wr_reference_select || i_wr_gain_rate);
    assign trig_long = trig_cfg || start_rise || i_wake_command || i_reset_cmd;

    // [R04] Two multiplier clocks
    pulse_stretch #(.LEN(MULT_PULSE)) u_sync (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RESETN),
        .i_trig(trig_sync),
        .i_tick(mult_tick),
        .o_pulse_n(pulse_sync_n)
    );
    // [R06] Two system clocks
    pulse_stretch #(.LEN(SYS_PULSE)) u_sel (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RESETN),
        .i_trig(trig_input_sel),
        .i_tick(1'b1),
        .o_pulse_n(pulse_sel_n)
    );
    // [R01] [R07] [R08] 32 modulator clocks, also on start rise and wake
    pulse_stretch #(.LEN(MOD_PULSE)) u_cfg (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RESETN),
        .i_trig(trig_long),
        .i_tick(mod_tick),
        .o_pulse_n(pulse_cfg_n)
    );

    // [R09] AND of active-low pulses; [R02] reset pin and command
    assign o_filter_reset_n = pulse_sync_n && pulse_sel_n && pulse_cfg_n &&
        !pin_rst && !i_reset_cmd;
    assign any_trig = trig_sync || trig_input_sel || trig_cfg || start_rise ||
        i_wake_command || i_reset_cmd || pin_rst;

    always_comb begin
        s_d = s_q;
        s_d.rst_pin_s1 = i_reset_pin_n;
        s_d.rst_pin_s2 = s_q.rst_pin_s1;
        s_d.start_s1 = i_start_pin;
        s_d.start_s2 = s_q.start_s1;
        s_d.start_prev = s_q.start_s2;
        s_d.sync_dly = {s_q.sync_dly[0], i_resync_cmd};
        // [R08] Restart divider on trigger, so the hold is 32 whole periods
        s_d.mod_div = (mod_tick || trig_long) ? 8'h00 : s_q.mod_div + 8'h01;
        s_d.mult_div = mult_tick ? 8'h00 : s_q.mult_div + 8'h01;
        s_d.conv_pulse = 1'b0;
        if (i_byte_done && i_wr_gain_rate) begin
            s_d.rate = i_gain_rate_rate;
        end
        // [R10] [R11] Choose table by newest reset source
        if (trig_sync || trig_input_sel) begin
            s_d.pend_short = 1'b1;
        end else if (any_trig) begin
            s_d.pend_short = 1'b0;
        end
        case (s_q.st)
            ST_RESET: begin
                if (o_filter_reset_n && !any_trig) begin
                    s_d.st = ST_FIRST;
                    s_d.short_first = s_q.pend_short;
                    s_d.cnt = s_q.pend_short ? first_short(s_q.rate) : first_long(s_q.rate);
                end
            end
            ST_FIRST, ST_NEXT: begin
                if (s_q.cnt > 20'h00001) begin
                    s_d.cnt = s_q.cnt - 20'h00001;
                end else begin
                    // [R13] Done low at end; [R12] steady count after
                    s_d.done_n = 1'b0;
                    s_d.conv_pulse = 1'b1;
                    s_d.st = ST_NEXT;
                    s_d.cnt = steady(s_q.rate);
                end
            end
            default: s_d.st = ST_RESET;
        endcase
        if (s_q.conv_pulse) begin
            s_d.done_n = 1'b1;
        end
        // [R15] Abandon conversion on new reset
        if (any_trig || !o_filter_reset_n) begin
            s_d.st = ST_RESET;
            s_d.done_n = 1'b1;
            s_d.conv_pulse = 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s_q <= '0;
            // Idle level of the pin, else release shows a false pin reset
            s_q.rst_pin_s1 <= 1'b1;
            s_q.rst_pin_s2 <= 1'b1;
            s_q.rate <= RATE_RESET;
            s_q.done_n <= 1'b1;
            s_q.st <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_conversion_done_flag_n = s_q.done_n;
    assign o_conv_pulse = s_q.conv_pulse;
endmodule // adc_filter_reset_timing
`default_nettype wire

// >>> filt_pkg.sv
`default_nettype none
package filt_pkg;
    // Rate codes, 5 SPS up to 2000 SPS
    localparam int RATE_W = 4;
    localparam int NUM_RATES = 10;
    localparam int CNT_W = 20;
    localparam int RSYNC_DELAY = 2;
    localparam int SYS_PULSE = 2;
    localparam int MULT_PULSE = 2;
    localparam int MOD_PULSE = 32;
    localparam int MOD_DIV = 4;
    localparam int MULT_DIV = 1;
    localparam logic [RATE_W-1:0] RATE_RESET = 4'h0;
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_FIRST = 2'b01,
        ST_NEXT  = 2'b10
    } conv_state_t;
endpackage
`default_nettype wire

// >>> pulse_stretch.sv
`timescale 1ns/1ps
`default_nettype none
// Holds an active-low pulse for LEN ticks of i_tick after a trigger.
module pulse_stretch #(
    parameter int LEN = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_trig,
    input wire logic i_tick,
    output logic o_pulse_n
);
    typedef struct packed {
        logic [6:0] cnt;
    } ps_t;
    ps_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (i_trig) begin
            s_d.cnt = 7'(LEN);
        end else if (i_tick && s_q.cnt != 7'h00) begin
            s_d.cnt = s_q.cnt - 7'h01;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_pulse_n = (s_q.cnt == 7'h00);
endmodule // pulse_stretch
`default_nettype wire

// >>> filt_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module filt_checker_properties (
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic i_reset_pin_n,
    input wire logic i_start_pin,
    input wire logic i_byte_done,
    input wire logic i_wr_input_select,
    input wire logic i_wr_bias_voltage,
    input wire logic i_resync_cmd,
    input wire logic i_reset_cmd,
    input wire logic o_filter_reset_n,
    input wire logic o_conversion_done_flag_n,
    input wire logic o_conv_pulse
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    sel_pulse_a:
    assert property (i_byte_done && i_wr_input_select |=> !o_filter_reset_n [*2])
        else $error("input select pulse short");
    resync_delay_a:
    assert property (i_resync_cmd |-> ##3 !o_filter_reset_n [*2])
        else $error("resync pulse misplaced");
    cfg_hold_a:
    assert property (i_byte_done && i_wr_bias_voltage |=> !o_filter_reset_n ##127 !o_filter_reset_n)
        else $error("config pulse short");
    cmd_reset_a:
    assert property (i_reset_cmd |-> !o_filter_reset_n)
        else $error("reset command ignored");
    pin_reset_a:
    assert property (!i_reset_pin_n [*3] |-> !o_filter_reset_n)
        else $error("reset pin ignored");
    start_rise_a:
    assert property ($rose(i_start_pin) |-> ##[1:6] !o_filter_reset_n)
        else $error("start rise ignored");
    done_pair_a:
    assert property (!o_conversion_done_flag_n |-> o_conv_pulse)
        else $error("done without pulse");
    done_single_a:
    assert property (!o_conversion_done_flag_n |=> o_conversion_done_flag_n)
        else $error("done held too long");
    no_done_rst_a:
    assert property (!o_filter_reset_n |=> o_conversion_done_flag_n)
        else $error("done during filter reset");
endmodule // filt_checker_properties
bind adc_filter_reset_timing filt_checker_properties i_chk (.I_CORE_CLK, .I_RESETN,
    .i_reset_pin_n, .i_start_pin, .i_byte_done, .i_wr_input_select, .i_wr_bias_voltage,
    .i_resync_cmd, .i_reset_cmd, .o_filter_reset_n, .o_conversion_done_flag_n, .o_conv_pulse);
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host stand-in: each op bit is registered into a strobe one clock later, held as long as the op bit
module host_model (
    input wire logic i_clk,
    input wire logic [6:0] i_op,
    output logic [6:0] o_strobe
);
    always_ff @(posedge i_clk) begin
        o_strobe <= i_op;
    end
endmodule // host_model
`default_nettype wire

// >>> adc_filter_reset_timing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_filter_reset_timing_bench;
    import filt_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_n = 1'b1;
    logic start = 1'b0;
    logic [3:0] rate = 4'h9;
    logic [6:0] op = 7'h00;
    logic [6:0] stb;
    logic flt_n;
    logic done_n;
    int fails = 0;
    int tests_run = 0;
    logic [6:0] ops [6] = '{7'h01, 7'h02, 7'h04, 7'h10, 7'h20, 7'h40};
    always #2 clk = ~clk;
    host_model i_host (.i_clk(clk), .i_op(op), .o_strobe(stb));
    adc_filter_reset_timing i_dut (.I_CORE_CLK(clk), .I_RESETN(rst_n), .i_reset_pin_n(pin_n),
        .i_start_pin(start), .i_byte_done(|stb[3:0]), .i_wr_input_select(stb[0]),
        .i_wr_bias_voltage(stb[1]), .i_wr_reference_select(stb[2]), .i_wr_gain_rate(stb[3]),
        .i_gain_rate_rate(rate), .i_resync_cmd(stb[4]), .i_reset_cmd(stb[5]),
        .i_wake_command(stb[6]), .o_filter_reset_n(flt_n), .o_conversion_done_flag_n(done_n),
        .o_conv_pulse());
    function automatic int first_n(input logic [3:0] r, input bit short);
        if (short) return (r == 4'h9) ? 2108 : 4156;
        return (r == 4'h9) ? 2370 : 4674;
    endfunction
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input int got, input int exp, input int tol);
        tests_run++;
        if (got < exp - tol || got > exp + tol) begin
            fails++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // Four-state compare, so an unknown level never passes
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [6:0] o);
        @(posedge clk);
        op <= o;
        @(posedge clk);
        op <= 7'h00;
    endtask
    task automatic wait_done(output int n);
        n = 0;
        while (done_n !== 1'b0 && n < 9000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Reset must show; the first conversion is timed from its release, the next from the first done, sampled mid-cycle
    task automatic measure(input bit short);
        int n;
        n = 0;
        @(negedge clk);
        while (flt_n !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check_bit(flt_n, 1'b0);
        while (flt_n !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        wait_done(n);
        check(n, first_n(rate, short), 3);
        @(negedge clk);
        wait_done(n);
        check(n + 1, (rate == 4'h9) ? 2048 : 4096, 0);
        @(posedge clk);
    endtask
    // Retrigger lands at a random point of a running conversion; op 0 raises start
    task automatic run_first(input logic [6:0] o, input bit short);
        repeat ($urandom_range(600)) @(posedge clk);
        if (o == 7'h00) begin
            @(posedge clk);
            start <= 1'b1;
        end else begin
            send(o);
        end
        measure(short);
    endtask
    initial begin
        logic [6:0] o;
        void'($urandom(47587));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        run_first(7'h08, 1'b0);
        run_first(7'h00, 1'b0);
        run_first(7'h01, 1'b1);
        run_first(7'h10, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rate <= ($urandom_range(1) == 1) ? 4'h9 : 4'h8;
            run_first(7'h08, 1'b0);
            o = ops[$urandom_range(5)];
            run_first(o, o == 7'h01 || o == 7'h10);
        end
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check_bit(flt_n, 1'b0);
        @(posedge clk);
        pin_n <= 1'b1;
        measure(1'b0);
        final_report();
    end
    initial begin
        #(4 * 95000);
        fails++;
        final_report();
    end
endmodule // adc_filter_reset_timing_bench
`default_nettype wire
